// ---- rtl/adcts_top.v ----
// Converter trigger, diagnostic, discharge and channel sequencing control
//
// Chosen here: strobed register access.
`include "adcts_defines.vh"
module adcts_top (
    input  wire                     ref_clk_i,
    input  wire                     reset_i,
    input  wire [`ADCTS_ADDR_W-1:0] addr_i,
    input  wire [7:0]               wdata_i,
    input  wire [7:0]               wmask_i,
    input  wire                     wr_i,
    input  wire                     rd_i,
    output reg  [7:0]               rdata_o,
    input  wire                     conv_enable_i,
    input  wire                     hw_trig_mode_i,
    input  wire                     sw_start_i,
    input  wire                     scan_mode_i,
    input  wire                     continuous_i,
    input  wire [1:0]               edge_sel_i,
    input  wire                     external_trigger_pin_i,
    input  wire                     timer_compare_event0_i,
    input  wire                     timer_compare_event1_i,
    output reg                      busy_o,
    output reg                      sample_o,
    output reg                      discharge_o,
    output reg                      conv_done_o,
    output reg  [4:0]               analog_input_o,
    output reg                      high_ref_sel_o,
    output reg                      low_ref_sel_o,
    output reg                      result_undef_o,
    output reg                      seq_end_o
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_DISC = 3'b100;
    localparam integer CONV_N  = `ADCTS_CONV_CYCLES - 1;
    localparam integer DISC_N  = `ADCTS_DISC_CYCLES - 1;
    localparam integer DONE_N  = `ADCTS_DISC_EXTRA - 1;
    localparam [7:0] CONV_LAST = CONV_N[7:0];
    localparam [7:0] DISC_LAST = DISC_N[7:0];
    localparam [7:0] DONE_AT   = DONE_N[7:0];

    reg  [7:0] chsel_reg;
    reg  [7:0] mode_reg;
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] cnt_reg;
    reg  [7:0] cnt_next;
    reg  [4:0] idx_reg;
    reg  [4:0] idx_next;
    reg  [1:0] kind_reg;
    reg  [1:0] kind_next;
    reg        pend_reg;
    reg        pend_next;
    reg        seq_reg;
    reg        seq_next;
    reg        done_next;
    reg        end_next;
    reg        last_elem;
    reg        undef_next;
    reg        sel_chsel;
    reg        sel_mode;
    wire       hw_trig;
    wire       diag_en;
    wire       disc_en;
    wire [4:0] chan_field;
    wire       start_req;

    assign diag_en    = mode_reg[`ADCTS_MODE_DIAG_BIT];
    assign disc_en    = mode_reg[`ADCTS_MODE_DISC_BIT];
    assign chan_field = chsel_reg[4:0];
    assign start_req  = conv_enable_i &
                        (hw_trig_mode_i ? hw_trig : sw_start_i);

    adcts_trig_sel u_trig (
        .ref_clk_i              (ref_clk_i),
        .reset_i                (reset_i),
        .trig_source_i          ({mode_reg[`ADCTS_MODE_TSRC_HI],
                                  mode_reg[`ADCTS_MODE_TSRC_LO]}),
        .edge_sel_i             (edge_sel_i),
        .external_trigger_pin_i (external_trigger_pin_i),
        .timer_compare_event0_i (timer_compare_event0_i),
        .timer_compare_event1_i (timer_compare_event1_i),
        .trig_o                 (hw_trig)
    );

    // Address decode
    always @* begin
        sel_chsel = 1'b0;
        sel_mode  = 1'b0;
        if (addr_i == `ADCTS_OFS_CHSEL) begin
            sel_chsel = 1'b1;
        end else if (addr_i == `ADCTS_OFS_MODE) begin
            sel_mode = 1'b1;
        end
    end

    // Register writes, masked per bit so single bit writes work
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            chsel_reg <= `ADCTS_CHSEL_RESET;
            mode_reg  <= `ADCTS_MODE_RESET;
        end else if (wr_i) begin
            if (sel_chsel) begin
                chsel_reg <= ((chsel_reg & ~wmask_i) |
                              (wdata_i & wmask_i)) &
                             `ADCTS_CHSEL_MASK;
            end else if (sel_mode) begin
                mode_reg <= ((mode_reg & ~wmask_i) |
                             (wdata_i & wmask_i)) &
                            `ADCTS_MODE_MASK;
            end
        end
    end

    // Read data in the cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && sel_chsel) begin
            rdata_o <= chsel_reg;
        end else if (rd_i && sel_mode) begin
            rdata_o <= mode_reg;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Last element of the current sequence
    always @* begin
        last_elem = 1'b0;
        if (!scan_mode_i) begin
            last_elem = 1'b1;
        end else if (diag_en) begin
            last_elem = (kind_reg == `ADCTS_KIND_REF_LO);
        end else begin
            last_elem = (idx_reg == chan_field);
        end
    end

    // Sequencer
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        idx_next   = idx_reg;
        kind_next  = kind_reg;
        pend_next  = pend_reg | start_req;
        done_next  = 1'b0;
        end_next   = 1'b0;
        seq_next   = seq_reg;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = 8'h00;
                if (pend_reg && conv_enable_i) begin
                    pend_next  = start_req;
                    state_next = ST_CONV;
                    if (seq_reg) begin
                        // Later scan elements keep the advanced index
                        idx_next  = idx_reg;
                    end else if (scan_mode_i || !diag_en) begin
                        idx_next  = scan_mode_i ? 5'h00 : chan_field;
                        kind_next = `ADCTS_KIND_INPUT;
                    end else begin
                        idx_next  = chan_field;
                        kind_next = (chan_field == 5'h00) ?
                                    `ADCTS_KIND_REF_HI :
                                    `ADCTS_KIND_REF_LO;
                    end
                end
            end
            ST_CONV: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == CONV_LAST) begin
                    cnt_next = 8'h00;
                    if (disc_en) begin
                        state_next = ST_DISC;
                    end else begin
                        done_next  = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_DISC: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == DONE_AT) begin
                    done_next = 1'b1;
                end
                if (cnt_reg == DISC_LAST) begin
                    cnt_next   = 8'h00;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!conv_enable_i) begin
            state_next = ST_IDLE;
            pend_next  = 1'b0;
            cnt_next   = 8'h00;
            seq_next   = 1'b0;
        end else if (done_next) begin
            if (last_elem) begin
                end_next = 1'b1;
                seq_next = 1'b0;
                if (continuous_i) begin
                    pend_next = 1'b1;
                end
            end else begin
                pend_next = 1'b1;
                seq_next  = 1'b1;
            end
        end
    end

    // Next element is chosen once the element's result is complete
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 8'h00;
            pend_reg  <= 1'b0;
            seq_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pend_reg  <= pend_next;
            seq_reg   <= seq_next;
        end
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            idx_reg  <= 5'h00;
            kind_reg <= `ADCTS_KIND_INPUT;
        end else if (state_reg == ST_IDLE) begin
            idx_reg  <= idx_next;
            kind_reg <= kind_next;
        end else if (done_next && !last_elem) begin
            if (kind_reg == `ADCTS_KIND_REF_HI) begin
                kind_reg <= `ADCTS_KIND_REF_LO;
            end else if (idx_reg == chan_field) begin
                kind_reg <= `ADCTS_KIND_REF_HI;
            end else begin
                idx_reg <= idx_reg + 5'h01;
            end
        end
    end

    // Undefined result for codes with no input or prohibited codes
    always @* begin
        undef_next = 1'b0;
        if (kind_next == `ADCTS_KIND_INPUT) begin
            undef_next = (idx_next > `ADCTS_LAST_INPUT);
        end else if (!scan_mode_i && diag_en) begin
            undef_next = (chan_field > 5'h01);
        end
    end

    // Registered outputs
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            busy_o         <= 1'b0;
            sample_o       <= 1'b0;
            discharge_o    <= 1'b0;
            conv_done_o    <= 1'b0;
            analog_input_o <= 5'h00;
            high_ref_sel_o <= 1'b0;
            low_ref_sel_o  <= 1'b0;
            result_undef_o <= 1'b0;
            seq_end_o      <= 1'b0;
        end else begin
            busy_o      <= (state_next != ST_IDLE);
            sample_o    <= (state_next == ST_CONV);
            discharge_o <= (state_next == ST_DISC);
            conv_done_o <= done_next;
            seq_end_o   <= end_next;
            if (state_next == ST_DISC) begin
                high_ref_sel_o <= 1'b0;
                low_ref_sel_o  <= 1'b1;
            end else if (state_reg == ST_IDLE &&
                         state_next == ST_CONV) begin
                analog_input_o <= idx_next;
                high_ref_sel_o <= (kind_next == `ADCTS_KIND_REF_HI);
                low_ref_sel_o  <= (kind_next == `ADCTS_KIND_REF_LO);
                result_undef_o <= undef_next;
            end else if (state_next == ST_IDLE) begin
                high_ref_sel_o <= 1'b0;
                low_ref_sel_o  <= 1'b0;
            end
        end
    end
endmodule // adcts_top

// ---- rtl/adcts_defines.vh ----
// Constants for the converter trigger and channel select block
`ifndef ADCTS_DEFINES_VH
`define ADCTS_DEFINES_VH
`define ADCTS_ADDR_W           32
`define ADCTS_OFS_CHSEL        32'hfffff202
`define ADCTS_OFS_MODE         32'hfffff203
`define ADCTS_CHSEL_RESET      8'h00
`define ADCTS_MODE_RESET       8'h00
`define ADCTS_CHSEL_MASK       8'h1f
`define ADCTS_MODE_MASK        8'h33
`define ADCTS_MODE_DIAG_BIT    5
`define ADCTS_MODE_DISC_BIT    4
`define ADCTS_MODE_TSRC_HI     1
`define ADCTS_MODE_TSRC_LO     0
`define ADCTS_TSRC_EXT         2'h0
`define ADCTS_TSRC_TMR0        2'h1
`define ADCTS_TSRC_TMR1        2'h2
`define ADCTS_EDGE_NONE        2'h0
`define ADCTS_EDGE_FALL        2'h1
`define ADCTS_EDGE_RISE        2'h2
`define ADCTS_EDGE_BOTH        2'h3
`define ADCTS_LAST_INPUT       5'h17
`define ADCTS_CLK_PERIOD_NS    100
`define ADCTS_CONV_TIME_NS     3200
`define ADCTS_CONV_CYCLES      ((`ADCTS_CONV_TIME_NS+`ADCTS_CLK_PERIOD_NS-1)/`ADCTS_CLK_PERIOD_NS)
`define ADCTS_DISC_CYCLES      4
`define ADCTS_DISC_EXTRA       2
`define ADCTS_KIND_INPUT       2'h0
`define ADCTS_KIND_REF_HI      2'h1
`define ADCTS_KIND_REF_LO      2'h2
`endif

// ---- rtl/adcts_trig_sel.v ----
// Hardware trigger source selection and external pin edge detection
`include "adcts_defines.vh"
module adcts_trig_sel (
    input  wire       ref_clk_i,
    input  wire       reset_i,
    input  wire [1:0] trig_source_i,
    input  wire [1:0] edge_sel_i,
    input  wire       external_trigger_pin_i,
    input  wire       timer_compare_event0_i,
    input  wire       timer_compare_event1_i,
    output reg        trig_o
);
    reg  pin_reg;
    reg  rise;
    reg  fall;
    reg  edge_hit;
    reg  trig_next;

    always @* begin
        rise = external_trigger_pin_i & ~pin_reg;
        fall = ~external_trigger_pin_i & pin_reg;
        edge_hit = 1'b0;
        if (edge_sel_i == `ADCTS_EDGE_FALL) begin
            edge_hit = fall;
        end else if (edge_sel_i == `ADCTS_EDGE_RISE) begin
            edge_hit = rise;
        end else if (edge_sel_i == `ADCTS_EDGE_BOTH) begin
            edge_hit = rise | fall;
        end
        trig_next = 1'b0;
        case (trig_source_i)
            `ADCTS_TSRC_EXT:  trig_next = edge_hit;
            `ADCTS_TSRC_TMR0: trig_next = timer_compare_event0_i;
            `ADCTS_TSRC_TMR1: trig_next = timer_compare_event1_i;
            default:          trig_next = 1'b0;
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            pin_reg <= 1'b0;
            trig_o  <= 1'b0;
        end else begin
            pin_reg <= external_trigger_pin_i;
            trig_o  <= trig_next;
        end
    end
endmodule // adcts_trig_sel

// ---- testbench/adcts_checker.sv ----
// Assertion checker for the converter trigger and channel select block
`include "adcts_defines.vh"
module adcts_checker (
    input wire logic                     ref_clk_i,
    input wire logic                     reset_i,
    input wire logic [`ADCTS_ADDR_W-1:0] addr_i,
    input wire logic                     rd_i,
    input wire logic [7:0]               rdata_o,
    input wire logic                     conv_enable_i,
    input wire logic                     busy_o,
    input wire logic                     sample_o,
    input wire logic                     discharge_o,
    input wire logic                     conv_done_o,
    input wire logic                     high_ref_sel_o,
    input wire logic                     low_ref_sel_o,
    input wire logic                     seq_end_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    logic [5:0] cnt_reg;
    // Length of the running sample phase
    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            cnt_reg <= 6'h00;
        else
            cnt_reg <= sample_o ? cnt_reg + 6'h01 : 6'h00;
    end
    sequence disc_run;
        discharge_o [*4] ##1 !discharge_o;
    endsequence
    sequence done_next;
        ##2 conv_done_o;
    endsequence
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    AST_CH_RSV: assert property ($past(rd_i) &&
        $past(addr_i) == `ADCTS_OFS_CHSEL |-> rdata_o[7:5] == 3'h0)
        else $error("channel reserved bits set");
    AST_MODE_RSV: assert property ($past(rd_i) &&
        $past(addr_i) == `ADCTS_OFS_MODE |-> (rdata_o & 8'hcc) == 8'h00)
        else $error("mode reserved bits set");
    AST_DISC_LEN: assert property ($rose(discharge_o) |-> disc_run)
        else $error("discharge not four cycles");
    AST_DISC_REF: assert property (discharge_o |-> low_ref_sel_o)
        else $error("discharge without low reference");
    AST_DISC_DONE: assert property ($rose(discharge_o) |-> done_next)
        else $error("done not two cycles after conversion");
    AST_CONV_LEN: assert property ($fell(sample_o) &&
        $past(conv_enable_i) |-> cnt_reg == 6'h20)
        else $error("conversion length wrong");
    AST_SEQ_DONE: assert property (seq_end_o |-> conv_done_o)
        else $error("sequence end without result");
    AST_REF_ONE: assert property (!(high_ref_sel_o && low_ref_sel_o))
        else $error("both references selected");
    AST_BUSY: assert property (sample_o || discharge_o |-> busy_o)
        else $error("activity without busy");
endmodule // adcts_checker

bind adcts_top adcts_checker u_chk (.*);

// ---- testbench/adcts_top_test.sv ----
// Self-checking bench for the converter trigger and channel select block
`include "adcts_defines.vh"
module adcts_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [31:0] addr_i = 32'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  wmask_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        conv_enable_i = 1'b0;
    logic        hw_trig_mode_i = 1'b0;
    logic        sw_start_i = 1'b0;
    logic        scan_mode_i = 1'b0;
    logic        continuous_i = 1'b0;
    logic [1:0]  edge_sel_i = `ADCTS_EDGE_RISE;
    logic        external_trigger_pin_i = 1'b0;
    logic        timer_compare_event0_i = 1'b0;
    logic        timer_compare_event1_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [4:0]  analog_input_o;
    logic        busy_o, sample_o, discharge_o, conv_done_o, seq_end_o;
    logic        high_ref_sel_o, low_ref_sel_o, result_undef_o;
    logic [7:0]  got[$];
    logic [7:0]  exq[$];
    logic [4:0]  chs[5] = '{5'h00, 5'h05, 5'h17, 5'h18, 5'h1f};
    int          n_fail = 0;
    int          tests_run = 0;
    int          lat, l0, i, s, e;
    logic        hit;

    adcts_top dut (.*);

    initial forever #50 ref_clk_i = ~ref_clk_i;

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(string what, logic [7:0] ex, logic [7:0] g);
        tests_run++;
        if (g !== ex) begin
            n_fail++;
            $display("Error %s expected %h got %h", what, ex, g);
        end
    endtask
    task automatic wr(logic [31:0] a, logic [7:0] d, logic [7:0] m);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wmask_i <= m;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [31:0] a, logic [7:0] ex);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", ex, rdata_o);
    endtask
    // Fire one start source, then record every element result
    task automatic go(int kind, logic busy_exp);
        int k;
        logic [7:0] cur;
        got.delete();
        cur = 8'h00;
        @(posedge ref_clk_i);
        sw_start_i <= (kind == 0);
        external_trigger_pin_i <= (kind == 1);
        timer_compare_event0_i <= (kind == 2);
        timer_compare_event1_i <= (kind == 3);
        @(posedge ref_clk_i);
        {sw_start_i, external_trigger_pin_i} <= 2'b00;
        {timer_compare_event0_i, timer_compare_event1_i} <= 2'b00;
        for (k = 0; k < 8 && busy_o !== 1'b1; k++)
            tick();
        chk("busy", {7'h00, busy_exp}, {7'h00, busy_o});
        for (k = 0; k < 3000 && busy_exp; k++) begin
            // Element identity is taken while it is being sampled
            if (sample_o === 1'b1)
                cur = {high_ref_sel_o, low_ref_sel_o, result_undef_o,
                    (high_ref_sel_o | low_ref_sel_o | result_undef_o)
                    ? 5'h00 : analog_input_o};
            if (conv_done_o === 1'b1) begin
                if (got.size() == 0)
                    lat = k;
                got.push_back(cur);
            end
            if (seq_end_o === 1'b1)
                break;
            tick();
        end
        for (k = 0; k < 10 && busy_o !== 1'b0; k++)
            tick();
    endtask
    task automatic cmp_seq();
        chk("count", exq.size(), got.size());
        foreach (exq[j])
            chk("element", exq[j], got[j]);
        exq.delete();
    endtask
    task automatic final_report();
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        $display("Error watchdog expected finish got timeout");
        final_report();
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        conv_enable_i <= 1'b1;
        rd(`ADCTS_OFS_CHSEL, 8'h00);
        rd(`ADCTS_OFS_MODE, 8'h00);
        wr(`ADCTS_OFS_CHSEL, 8'hff, 8'hff);
        rd(`ADCTS_OFS_CHSEL, 8'h1f);
        wr(`ADCTS_OFS_MODE, 8'h32, 8'hff);
        rd(`ADCTS_OFS_MODE, 8'h32);
        wr(32'hfffff204, 8'hff, 8'hff);
        rd(32'hfffff204, 8'h00);
        wr(`ADCTS_OFS_MODE, 8'h00, 8'h30);
        rd(`ADCTS_OFS_MODE, 8'h02);
        wr(`ADCTS_OFS_CHSEL, 8'h00, 8'h0f);
        rd(`ADCTS_OFS_CHSEL, 8'h10);
        wr(`ADCTS_OFS_MODE, 8'h00, 8'hff);
        for (i = 0; i < 5; i++) begin
            wr(`ADCTS_OFS_CHSEL, {3'h0, chs[i]}, 8'hff);
            exq.push_back(chs[i] > 5'h17 ? 8'h20 : {3'h0, chs[i]});
            go(0, 1'b1);
            cmp_seq();
            if (i == 0) begin
                l0 = lat;
                chk("conv cycles", `ADCTS_CONV_CYCLES, l0);
            end
        end
        wr(`ADCTS_OFS_CHSEL, 8'h17, 8'hff);
        for (i = 1; i >= 0; i--) begin
            wr(`ADCTS_OFS_MODE, i ? 8'h10 : 8'h00, 8'hff);
            exq.push_back(8'h17);
            go(0, 1'b1);
            cmp_seq();
            chk("latency", l0 + 2 * i, lat);
        end
        wr(`ADCTS_OFS_MODE, 8'h20, 8'hff);
        for (i = 0; i < 3; i++) begin
            wr(`ADCTS_OFS_CHSEL, i, 8'hff);
            exq.push_back(i == 2 ? 8'h60 : 8'h80 >> i);
            go(0, 1'b1);
            cmp_seq();
        end
        @(posedge ref_clk_i);
        scan_mode_i <= 1'b1;
        wr(`ADCTS_OFS_CHSEL, 8'h03, 8'hff);
        for (s = 1; s >= 0; s--) begin
            wr(`ADCTS_OFS_MODE, s ? 8'h20 : 8'h00, 8'hff);
            for (e = 0; e < 4; e++)
                exq.push_back(e);
            if (s) begin
                exq.push_back(8'h80);
                exq.push_back(8'h40);
            end
            go(0, 1'b1);
            cmp_seq();
        end
        @(posedge ref_clk_i);
        scan_mode_i <= 1'b0;
        continuous_i <= 1'b1;
        exq.push_back(8'h03);
        go(0, 1'b1);
        cmp_seq();
        tick();
        chk("restart", 8'h01, {7'h00, busy_o});
        @(posedge ref_clk_i);
        conv_enable_i <= 1'b0;
        continuous_i <= 1'b0;
        tick();
        tick();
        chk("abort", 8'h00, {7'h00, busy_o});
        @(posedge ref_clk_i);
        conv_enable_i <= 1'b1;
        hw_trig_mode_i <= 1'b1;
        wr(`ADCTS_OFS_CHSEL, 8'h02, 8'hff);
        for (s = 0; s < 4; s++) begin
            // Last pass: pin source on falling edges, never code 11
            wr(`ADCTS_OFS_MODE, (s == 3) ? 8'h00 : s, 8'hff);
            edge_sel_i <= (s == 3) ? `ADCTS_EDGE_FALL : `ADCTS_EDGE_RISE;
            for (e = 1; e < 4; e++) begin
                hit = (s == 3) ? (e == 1) : (e - 1 == s);
                if (hit)
                    exq.push_back(8'h02);
                go(e, hit);
                cmp_seq();
            end
        end
        final_report();
    end
endmodule // adcts_top_test
